// ===== hw/dvb_pkg.sv
// Package: register map, field layout and decoded control types for the output path controls
package dvb_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] DVB_IDX_RATE_DIV     = 8'h4e;
   localparam logic [7:0] DVB_IDX_DAC_CTRL     = 8'h4f;
   localparam logic [7:0] DVB_IDX_VOLUME_BYPASS_CONTROL   = 8'h54;
   localparam logic [7:0] DVB_IDX_STATUS       = 8'h60;

   // Reset values
   localparam logic [7:0] DVB_RST_RATE_DIV     = 8'h00;
   localparam logic [7:0] DVB_RST_DAC_CTRL     = 8'h00;
   localparam logic [7:0] DVB_RST_VOLUME_BYPASS_CONTROL   = 8'h00;

   // Writable bit masks; reserved bits store nothing and read as zero
   localparam logic [7:0] DVB_MASK_RATE_DIV    = 8'h07;
   localparam logic [7:0] DVB_MASK_DAC_CTRL    = 8'hf8;
   localparam logic [7:0] DVB_MASK_VOLUME_BYPASS_CONTROL  = 8'h3f;

   // Field positions
   localparam int DVB_RATE_HI     = 7;
   localparam int DVB_RATE_LO     = 6;
   localparam int DVB_INTP_HI     = 5;
   localparam int DVB_INTP_LO     = 3;
   localparam int DVB_BY_OUT1     = 5;
   localparam int DVB_BY_OUT0     = 4;
   localparam int DVB_BY_IN_HI    = 3;
   localparam int DVB_RDIV_HI     = 2;

   // Divide factors for the fast-rate divider
   localparam logic [4:0] DVB_DIV_8  = 5'h08;
   localparam logic [4:0] DVB_DIV_9  = 5'h09;
   localparam logic [4:0] DVB_DIV_10 = 5'h0a;
   localparam logic [4:0] DVB_DIV_12 = 5'h0c;
   localparam logic [4:0] DVB_DIV_14 = 5'h0e;
   localparam logic [4:0] DVB_DIV_16 = 5'h10;

   // Core rate selector code that routes the fast divider
   localparam logic [1:0] DVB_CORE_RATE_FAST = 2'h3;

   // DAC decimation factors from the core rate
   localparam logic [3:0] DVB_DEC_CORE    = 4'h1;
   localparam logic [3:0] DVB_DEC_QUARTER = 4'h4;
   localparam logic [3:0] DVB_DEC_EIGHTH  = 4'h8;

   // DAC rate code
   typedef enum logic [1:0]
   {
      DVB_RATE_CORE    = 2'b00,
      DVB_RATE_QUARTER = 2'b01,
      DVB_RATE_EIGHTH  = 2'b10,
      DVB_RATE_RSVD    = 2'b11
   } dvb_rate_e;

   typedef enum logic [2:0]
   {
      DVB_INTP_COMP_BOTH = 3'b000,
      DVB_INTP_ZOH_0     = 3'b001,
      DVB_INTP_ZOH_1     = 3'b010,
      DVB_INTP_ZOH_BOTH  = 3'b011,
      DVB_INTP_LIN_0     = 3'b100,
      DVB_INTP_LIN_1     = 3'b101,
      DVB_INTP_LIN_BOTH  = 3'b110,
      DVB_INTP_UNDEF     = 3'b111
   } dvb_intp_e;

   // Per-channel interpolator kind
   typedef enum logic [1:0]
   {
      DVB_KIND_COMP = 2'b00,
      DVB_KIND_ZOH  = 2'b01,
      DVB_KIND_LIN  = 2'b10
   } dvb_kind_e;

   // Decoded controls handed to the datapath
   typedef struct packed
   {
      logic [4:0] fast_div;
      logic [3:0] dac_rate_div;
      dvb_kind_e  out1_kind;
      dvb_kind_e  out0_kind;
      logic       out1_volume_bypass_control;
      logic       out0_volume_bypass_control;
      logic [3:0] in_volume_bypass_control;
   } dvb_ctrl_s;

   // Controls in reset: divider idle, core rate, compensated filters, volume active on all paths
   localparam dvb_ctrl_s DVB_RST_CTRL = '{fast_div: DVB_DIV_8, dac_rate_div: DVB_DEC_CORE, out1_kind: DVB_KIND_COMP,
                                          out0_kind: DVB_KIND_COMP, default: '0};

endpackage

// ===== hw/dvb_ctrl.sv
// Output-path control register bank with classic Wishbone slave
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Fast divider codes 011/100/101 give 12/14/16.
// - DAC rate: core, quarter, eighth; 11 reserved.
// - Interp codes 000-011 select compensated/ZOH per channel.
// - Codes 100-110 linear; others stay compensated.
// - DAC control register resets to zero.
// - Bypass bits 5,4 bypass output channel volume.
// - Bypass bits 3..0 bypass input path volume.
// - Bypass register resets to zero.
module dvb_ctrl
   import dvb_pkg::*;
(
   input  wire logic        CLOCK_IN,
   input  wire logic        ARST_N_IN,
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [9:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   input  wire logic        CORE_RUN_IN,
   input  wire logic [1:0]  CORE_RATE_SELECT_IN,
   output logic [31:0]      WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   output logic             WB_ERR_OUT,
   output dvb_ctrl_s        CTRL_OUT
);

   logic [7:0]  rate_div_reg;
   logic [7:0]  dac_ctrl;
   logic [7:0]  volume_bypass_control;
   logic [7:0]  next_rate_div_reg;
   logic [7:0]  next_dac_ctrl;
   logic [7:0]  next_volume_bypass_control;
   logic [31:0] next_dat;
   logic        next_ack;
   logic        next_err;
   dvb_ctrl_s   next_ctrl;
   logic        req;
   logic [7:0]  idx;
   logic        hit_rdiv;
   logic        hit_dac;
   logic        hit_byp;
   logic        hit_stat;
   logic [7:0]  status;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rd_byte;

   // Fast-rate divider factor from its code
   function automatic logic [4:0] dvb_div_factor(input logic [2:0] code);
      case (code)
         3'b000:  dvb_div_factor = DVB_DIV_8;
         3'b001:  dvb_div_factor = DVB_DIV_9;
         3'b010:  dvb_div_factor = DVB_DIV_10;
         3'b011:  dvb_div_factor = DVB_DIV_12;
         3'b100:  dvb_div_factor = DVB_DIV_14;
         3'b101:  dvb_div_factor = DVB_DIV_16;
         default: dvb_div_factor = DVB_DIV_8;
      endcase
   endfunction

   // Interpolator kind of one channel; sel picks channel one
   function automatic dvb_kind_e dvb_kind(input logic [2:0] code, input logic sel);
      dvb_kind = DVB_KIND_COMP;
      case (dvb_intp_e'(code))
         DVB_INTP_ZOH_0:    dvb_kind = sel ? DVB_KIND_COMP : DVB_KIND_ZOH;
         DVB_INTP_ZOH_1:    dvb_kind = sel ? DVB_KIND_ZOH : DVB_KIND_COMP;
         DVB_INTP_ZOH_BOTH: dvb_kind = DVB_KIND_ZOH;
         DVB_INTP_LIN_0:    dvb_kind = sel ? DVB_KIND_COMP : DVB_KIND_LIN;
         DVB_INTP_LIN_1:    dvb_kind = sel ? DVB_KIND_LIN : DVB_KIND_COMP;
         DVB_INTP_LIN_BOTH: dvb_kind = DVB_KIND_LIN;
         // Undefined code 111 falls back to compensated, the safest filter
         default:           dvb_kind = DVB_KIND_COMP;
      endcase
   endfunction

   assign req      = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
   assign idx      = WB_ADR_IN[9:2];
   assign hit_rdiv = (idx == DVB_IDX_RATE_DIV);
   assign hit_dac  = (idx == DVB_IDX_DAC_CTRL);
   assign hit_byp  = (idx == DVB_IDX_VOLUME_BYPASS_CONTROL);
   assign hit_stat = (idx == DVB_IDX_STATUS);
   assign status   = {5'h00, CORE_RUN_IN, CORE_RATE_SELECT_IN};
   // Only the low byte lane carries a register; the other lanes are ignored
   assign wr_en    = req && WB_WE_IN && WB_SEL_IN[0];
   assign rd_en    = req && !WB_WE_IN;

   // Register file: next values
   always_comb
   begin
      next_rate_div_reg = rate_div_reg;
      next_dac_ctrl     = dac_ctrl;
      next_volume_bypass_control   = volume_bypass_control;
      if (wr_en)
      begin
         // Divider only updates while the core is halted, so a running core never sees a rate step
         if (hit_rdiv && !CORE_RUN_IN)
         begin
            next_rate_div_reg = WB_DAT_IN[7:0] & DVB_MASK_RATE_DIV;
         end
         if (hit_dac)
         begin
            next_dac_ctrl = WB_DAT_IN[7:0] & DVB_MASK_DAC_CTRL;
         end
         if (hit_byp)
         begin
            next_volume_bypass_control = WB_DAT_IN[7:0] & DVB_MASK_VOLUME_BYPASS_CONTROL;
         end
      end
   end

   // Bus answer: one ack or err pulse per request, read data only beside an ack
   always_comb
   begin
      next_ack = 1'b0;
      next_err = 1'b0;
      rd_byte  = 8'h00;
      if (req)
      begin
         next_ack = hit_rdiv || hit_dac || hit_byp || hit_stat;
         // Unmapped words answer with err so software sees a bad address at once
         next_err = !next_ack;
      end
      // Write cycles return zero so stale data never rides an ack
      if (rd_en)
      begin
         if (hit_rdiv)
         begin
            rd_byte = rate_div_reg;
         end
         if (hit_dac)
         begin
            rd_byte = dac_ctrl;
         end
         if (hit_byp)
         begin
            rd_byte = volume_bypass_control;
         end
         if (hit_stat)
         begin
            rd_byte = status;
         end
      end
      next_dat = {24'h00_0000, rd_byte};
   end

   // Control outputs: decoded from the values that the same edge stores
   always_comb
   begin
      // Divider is only meaningful at the fast core rate
      next_ctrl.fast_div = (CORE_RATE_SELECT_IN == DVB_CORE_RATE_FAST)
                           ? dvb_div_factor(next_rate_div_reg[DVB_RDIV_HI:0]) : DVB_DIV_8;
      case (dvb_rate_e'(next_dac_ctrl[DVB_RATE_HI:DVB_RATE_LO]))
         DVB_RATE_CORE:    next_ctrl.dac_rate_div = DVB_DEC_CORE;
         DVB_RATE_QUARTER: next_ctrl.dac_rate_div = DVB_DEC_QUARTER;
         DVB_RATE_EIGHTH:  next_ctrl.dac_rate_div = DVB_DEC_EIGHTH;
         // Reserved code keeps the core rate
         default:          next_ctrl.dac_rate_div = DVB_DEC_CORE;
      endcase
      next_ctrl.out0_kind       = dvb_kind(next_dac_ctrl[DVB_INTP_HI:DVB_INTP_LO], 1'b0);
      next_ctrl.out1_kind       = dvb_kind(next_dac_ctrl[DVB_INTP_HI:DVB_INTP_LO], 1'b1);
      next_ctrl.out1_volume_bypass_control = next_volume_bypass_control[DVB_BY_OUT1];
      next_ctrl.out0_volume_bypass_control = next_volume_bypass_control[DVB_BY_OUT0];
      next_ctrl.in_volume_bypass_control   = next_volume_bypass_control[DVB_BY_IN_HI:0];
   end

   // Register file storage
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         rate_div_reg <= DVB_RST_RATE_DIV;
         dac_ctrl     <= DVB_RST_DAC_CTRL;
         volume_bypass_control   <= DVB_RST_VOLUME_BYPASS_CONTROL;
      end
      else
      begin
         rate_div_reg <= next_rate_div_reg;
         dac_ctrl     <= next_dac_ctrl;
         volume_bypass_control   <= next_volume_bypass_control;
      end
   end

   // Answer registers; req masks a standing answer, so ack and err last one cycle
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         WB_DAT_OUT <= 32'h0000_0000;
         WB_ACK_OUT <= 1'b0;
         WB_ERR_OUT <= 1'b0;
      end
      else
      begin
         WB_DAT_OUT <= next_dat;
         WB_ACK_OUT <= next_ack;
         WB_ERR_OUT <= next_err;
      end
   end

   // Controls change in the edge of the write, so the datapath never sees a half-applied setting
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         CTRL_OUT <= DVB_RST_CTRL;
      end
      else
      begin
         CTRL_OUT <= next_ctrl;
      end
   end

endmodule

// ===== sim/dvb_ctrl_props.sv
// Checker for the output-path control register bank
`timescale 1ns/1ps
module dvb_ctrl_props
   import dvb_pkg::*;
(
   input wire logic        CLOCK_IN,
   input wire logic        ARST_N_IN,
   input wire logic        WB_CYC_IN,
   input wire logic        WB_STB_IN,
   input wire logic        WB_WE_IN,
   input wire logic [9:0]  WB_ADR_IN,
   input wire logic [3:0]  WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic        CORE_RUN_IN,
   input wire logic [1:0]  CORE_RATE_SELECT_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic        WB_ACK_OUT,
   input wire logic        WB_ERR_OUT,
   input wire dvb_ctrl_s   CTRL_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!ARST_N_IN);
   logic [7:0] idx;
   logic       req;
   logic       map;
   logic       wr;
   assign idx = WB_ADR_IN[9:2];
   // A request is taken only while no answer stands
   assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
   assign map = idx inside {DVB_IDX_RATE_DIV, DVB_IDX_DAC_CTRL, DVB_IDX_VOLUME_BYPASS_CONTROL, DVB_IDX_STATUS};
   assign wr  = req && map && WB_WE_IN && WB_SEL_IN[0];
   property p_ack; req && map |=> WB_ACK_OUT && !WB_ERR_OUT; endproperty
   a_ack: assert property (p_ack) else $error("missing ack");
   property p_err; req && !map |=> WB_ERR_OUT && !WB_ACK_OUT; endproperty
   a_err: assert property (p_err) else $error("missing err");
   property p_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_byp; wr && idx == DVB_IDX_VOLUME_BYPASS_CONTROL |=>
      {CTRL_OUT.out1_volume_bypass_control, CTRL_OUT.out0_volume_bypass_control, CTRL_OUT.in_volume_bypass_control} == $past(WB_DAT_IN[5:0]);
   endproperty
   a_byp: assert property (p_byp) else $error("bypass wrong");
   property p_rate; wr && idx == DVB_IDX_DAC_CTRL && WB_DAT_IN[7:6] == 2'b10 |=> CTRL_OUT.dac_rate_div == 4'h8;
   endproperty
   a_rate: assert property (p_rate) else $error("rate wrong");
   property p_zoh; wr && idx == DVB_IDX_DAC_CTRL && WB_DAT_IN[5:3] == 3'b011 |=>
      {CTRL_OUT.out1_kind, CTRL_OUT.out0_kind} == 4'h5;
   endproperty
   a_zoh: assert property (p_zoh) else $error("hold kind wrong");
   property p_lin; wr && idx == DVB_IDX_DAC_CTRL && WB_DAT_IN[5:3] == 3'b110 |=>
      {CTRL_OUT.out1_kind, CTRL_OUT.out0_kind} == 4'ha;
   endproperty
   a_lin: assert property (p_lin) else $error("linear kind wrong");
   property p_fast; CORE_RATE_SELECT_IN != 2'b11 |=> CTRL_OUT.fast_div == DVB_DIV_8; endproperty
   a_fast: assert property (p_fast) else $error("divider not idle");
   c_wr: cover property (wr ##1 WB_ACK_OUT);
   c_rd: cover property (req && !WB_WE_IN);
   c_err: cover property (WB_ERR_OUT);
endmodule
bind dvb_ctrl dvb_ctrl_props u_props (.CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
   .WB_DAT_IN(WB_DAT_IN), .CORE_RUN_IN(CORE_RUN_IN), .CORE_RATE_SELECT_IN(CORE_RATE_SELECT_IN),
   .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .WB_ERR_OUT(WB_ERR_OUT), .CTRL_OUT(CTRL_OUT));

// ===== sim/dvb_ctrl_test.sv
// Self-checking bench for the output-path control register bank
`timescale 1ns/1ps
module dvb_ctrl_test
   import dvb_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, ack, err;
   logic [1:0]  rsel = 2'b00;
   logic [3:0]  sel = 4'h1;
   logic [9:0]  adr = 10'h000;
   logic [31:0] dat = 32'h0000_0000, rdat;
   logic [33:0] expq[$], e;
   dvb_ctrl_s   ctrl;
   int          bad_count = 0, checks_done = 0, c, r, v;
   logic [4:0]  dv[3] = '{DVB_DIV_12, DVB_DIV_14, DVB_DIV_16};
   dvb_ctrl dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .CORE_RUN_IN(run), .CORE_RATE_SELECT_IN(rsel),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .CTRL_OUT(ctrl));
   always #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Note is {read, err, data}; called at a rising edge, returns one idle cycle later
   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d, input logic [33:0] n_e);
      int n = 0;
      expq.push_back(n_e);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      dat <= 32'(d);
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!(ack || err) && n < 20);
      if (!(ack || err))
      begin
         bad_count++;
         results();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rst();
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(32'(ctrl), 32'({DVB_DIV_8, 4'h1, 10'h000}));
      bus(1'b0, DVB_IDX_DAC_CTRL, 8'h00, {2'b10, 32'(DVB_RST_DAC_CTRL)});
      bus(1'b0, DVB_IDX_VOLUME_BYPASS_CONTROL, 8'h00, {2'b10, 32'(DVB_RST_VOLUME_BYPASS_CONTROL)});
   endtask
   function automatic logic [1:0] kd(input int k, input int ch);
      if (k == 3 || k == ch + 1)
         return DVB_KIND_ZOH;
      if (k == 6 || k == ch + 4)
         return DVB_KIND_LIN;
      return DVB_KIND_COMP;
   endfunction
   always @(posedge clk)
      if (ack || err)
      begin
         e = expq.pop_front();
         chk(32'(err), 32'(e[32]));
         if (e[33])
            chk(rdat, e[31:0]);
      end
   initial
   begin
      void'($urandom(49));
      rst();
      for (c = 0; c < 7; c++)
      begin
         r = $urandom_range(2);
         v = {r[1:0], c[2:0], 3'b000};
         bus(1'b1, DVB_IDX_DAC_CTRL, v[7:0], 34'h0);
         chk(32'({ctrl.out1_kind, ctrl.out0_kind}), 32'({kd(c, 1), kd(c, 0)}));
         chk(32'(ctrl.dac_rate_div), (r == 0) ? 1 : (r == 1) ? 4 : 8);
         bus(1'b0, DVB_IDX_DAC_CTRL, 8'h00, {2'b10, 32'(v)});
      end
      // Lowest-latency picks: hold at a quarter of the core rate, linear at an eighth
      bus(1'b1, DVB_IDX_DAC_CTRL, 8'h58, 34'h0);
      chk(32'({ctrl.out1_kind, ctrl.out0_kind}), 32'h0000_0005);
      chk(32'(ctrl.dac_rate_div), 32'h0000_0004);
      bus(1'b1, DVB_IDX_DAC_CTRL, 8'hb0, 34'h0);
      chk(32'({ctrl.out1_kind, ctrl.out0_kind}), 32'h0000_000a);
      chk(32'(ctrl.dac_rate_div), 32'h0000_0008);
      repeat (4)
      begin
         v = $urandom_range(63);
         bus(1'b1, DVB_IDX_VOLUME_BYPASS_CONTROL, v[7:0], 34'h0);
         chk(32'({ctrl.out1_volume_bypass_control, ctrl.out0_volume_bypass_control, ctrl.in_volume_bypass_control}), 32'(v));
         bus(1'b0, DVB_IDX_VOLUME_BYPASS_CONTROL, 8'h00, {2'b10, 32'(v)});
      end
      // A write without the low byte lane leaves the register alone
      sel <= 4'h0;
      bus(1'b1, DVB_IDX_VOLUME_BYPASS_CONTROL, 8'(63 - v), 34'h0);
      sel <= 4'h1;
      bus(1'b0, DVB_IDX_VOLUME_BYPASS_CONTROL, 8'h00, {2'b10, 32'(v)});
      rsel <= 2'b11;
      for (c = 0; c < 3; c++)
      begin
         bus(1'b1, DVB_IDX_RATE_DIV, 8'(c + 3), 34'h0);
         chk(32'(ctrl.fast_div), 32'(dv[c]));
         bus(1'b0, DVB_IDX_RATE_DIV, 8'h00, {2'b10, 32'(c + 3)});
      end
      // The divider must not move while the core runs
      run <= 1'b1;
      bus(1'b1, DVB_IDX_RATE_DIV, 8'h03, 34'h0);
      chk(32'(ctrl.fast_div), 32'(DVB_DIV_16));
      bus(1'b0, DVB_IDX_RATE_DIV, 8'h00, {2'b10, 32'h0000_0005});
      rsel <= 2'b01;
      repeat (2) @(posedge clk);
      chk(32'(ctrl.fast_div), 32'(DVB_DIV_8));
      // Status shows the run flag in bit 2 and the rate selector below it
      bus(1'b0, DVB_IDX_STATUS, 8'h00, {2'b10, 32'h0000_0005});
      bus(1'b1, 8'h00, 8'h5a, {2'b01, 32'h0000_0000});
      rst();
      chk(32'(expq.size()), 32'h0000_0000);
      results();
   end
endmodule
